// ### hw/lane_steer.sv
// Byte-lane steering between core load/store path and 32-bit data bus
//
// Function
// RULE1: Internal registers always use little-endian lanes
// RULE2: One order select bit picks external order
// RULE3: Bytes numbered upward, four form one word
// RULE4: Little-endian: byte 0 on lanes 7:0
// RULE5: Big-endian: byte 0 on lanes 31:24
// RULE6: Order affects only load and store transfers
// RULE7: Misaligned word read rotates right by offset
// RULE8: Byte read takes selected lane, zero-extended
// RULE9: Word write drives register unchanged onto lanes
// RULE10: Byte write replicates low byte, one lane active
// RULE11: Order select resets to little-endian
`timescale 1ns/10ps
`default_nettype none
module lane_steer
  import lane_steer_pkg::*;
(
  input  wire logic              ref_clk,      // Processor bus clock
  input  wire logic              rst,          // Async reset, active high
  input  wire logic              order_wr,     // Load new order select
  input  wire logic              order_big,    // New order, 1 = big-endian
  input  wire logic              req,          // Load/store transfer request
  input  wire logic              req_write,    // 1 = store, 0 = load
  input  wire logic              req_byte,     // 1 = byte, 0 = word
  input  wire logic              req_internal, // Target is internal register
  input  wire logic [1:0]        req_ofs,      // Byte offset in word
  input  wire logic [DATA_W-1:0] store_data,   // Core register for stores
  input  wire logic [DATA_W-1:0] bus_rdata,    // Data lanes from memory
  output logic                   order_q,      // Current order select
  output logic                   load_valid,   // Load result valid, pulse
  output logic [DATA_W-1:0]      load_data,    // Steered load result
  output logic                   store_valid,  // Store lanes valid, pulse
  output logic [DATA_W-1:0]      bus_wdata,    // Data lanes to memory
  output logic [LANES-1:0]       lane_en       // Active write lanes
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  localparam int BYTE_W = 8;

  generate
    if (DATA_W != BYTE_W * LANES) begin : g_width_check
      $error("Data width must hold exactly LANES bytes");
    end
    if (LANES != 4) begin : g_lane_check
      $error("Two offset bits serve exactly four lanes");
    end
    if ($bits(LANES_ALL) != LANES) begin : g_mask_check
      $error("Full lane mask must match the lane count");
    end
  endgenerate

  // ------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------
  // Lane that carries a byte offset under one order
  function automatic logic [1:0] lane_of(input logic big, input logic [1:0] ofs);
    lane_of = big ? ~ofs : ofs; // RULE3 RULE4 RULE5
  endfunction : lane_of

  // One-hot mask of a lane index
  function automatic logic [LANES-1:0] lane_mask(input logic [1:0] lane);
    lane_mask = LANES'(1) << lane;
  endfunction : lane_mask

  // ------------------------------------------------------------
  // Internal signals
  // ------------------------------------------------------------
  logic                order_d;
  logic                eff_big;
  logic                is_byte;
  logic                is_load;
  logic                is_store;
  logic                load_v_d;
  logic                store_v_d;
  size_type            size;
  logic [1:0]          sel_lane;
  logic [LANES-1:0]    rd_mask;
  logic [LANES-1:0]    wr_mask;
  logic [7:0]          rd_lane   [LANES];
  logic [7:0]          st_lane   [LANES];
  logic [7:0]          lane_pick [LANES];
  logic [7:0]          pick_or   [LANES+1];
  logic [1:0]          rot_src   [LANES];
  logic [7:0]          sel_byte;
  logic [DATA_W-1:0]   rot_word;
  logic [DATA_W-1:0]   byte_word;
  logic [DATA_W-1:0]   load_d;
  logic [DATA_W-1:0]   load_hold_d;
  logic [DATA_W-1:0]   wdata_d;
  logic [DATA_W-1:0]   wdata_hold_d;
  logic [LANES-1:0]    lane_d;

  // ------------------------------------------------------------
  // Request decoding
  // ------------------------------------------------------------
  assign size      = req_byte ? SIZE_BYTE : SIZE_WORD;
  assign is_byte   = (size == SIZE_BYTE);
  assign is_load   = req & ~req_write; // RULE6
  assign is_store  = req & req_write; // RULE6
  assign load_v_d  = is_load;
  assign store_v_d = is_store;

  // ------------------------------------------------------------
  // Byte order
  // ------------------------------------------------------------
  // A request on the updating edge still sees the old order
  assign order_d   = order_wr ? order_big : order_q; // RULE2
  // Internal registers stay little-endian
  assign eff_big   = order_q & ~req_internal; // RULE1 RULE6
  assign sel_lane  = lane_of(eff_big, req_ofs); // RULE4 RULE5
  // Same lane decode for byte reads and byte writes
  assign rd_mask   = lane_mask(sel_lane); // RULE8
  assign wr_mask   = lane_mask(sel_lane); // RULE10

  // ------------------------------------------------------------
  // Lane split
  // ------------------------------------------------------------
  // Lane n is bits 8n+7:8n on both data buses
  for (genvar i = 0; i < LANES; i++) begin : g_split
    assign rd_lane[i] = bus_rdata[8*i +: 8];
    assign st_lane[i] = store_data[8*i +: 8];
  end : g_split

  // ------------------------------------------------------------
  // Load path
  // ------------------------------------------------------------
  // Rotation does not depend on the order
  for (genvar i = 0; i < LANES; i++) begin : g_load_lane
    assign rot_src[i]         = 2'(i) + req_ofs; // RULE7
    assign rot_word[8*i +: 8] = rd_lane[rot_src[i]]; // RULE7
    assign lane_pick[i]       = rd_mask[i] ? rd_lane[i] : 8'h00; // RULE8
    assign pick_or[i+1]       = pick_or[i] | lane_pick[i]; // RULE8
  end : g_load_lane

  assign pick_or[0]  = 8'h00;
  assign sel_byte    = pick_or[LANES]; // RULE8
  assign byte_word   = {{(DATA_W-BYTE_W){1'h0}}, sel_byte}; // RULE8
  assign load_d      = is_byte ? byte_word : rot_word; // RULE7 RULE8
  assign load_hold_d = is_load ? load_d : load_data;

  // ------------------------------------------------------------
  // Store path
  // ------------------------------------------------------------
  // Byte stores copy the low byte to every lane
  for (genvar i = 0; i < LANES; i++) begin : g_store_lane
    assign wdata_d[8*i +: 8] = is_byte ? st_lane[0] : st_lane[i]; // RULE9 RULE10
    assign lane_d[i]         = is_byte ? wr_mask[i] : LANES_ALL[i]; // RULE9 RULE10
  end : g_store_lane

  assign wdata_hold_d = is_store ? wdata_d : bus_wdata;

  // ------------------------------------------------------------
  // Order register
  // ------------------------------------------------------------
  // Little-endian after reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      order_q <= ORDER_RESET; // RULE11
    end else begin
      order_q <= order_d;
    end
  end

  // ------------------------------------------------------------
  // Transfer pulses
  // ------------------------------------------------------------
  // One-cycle pulse per accepted load
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_valid <= 1'h0;
    end else begin
      load_valid <= load_v_d;
    end
  end

  // One-cycle pulse per accepted store
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      store_valid <= 1'h0;
    end else begin
      store_valid <= store_v_d;
    end
  end

  // ------------------------------------------------------------
  // Data and lane registers
  // ------------------------------------------------------------
  // Holds the last load result
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      load_data <= DATA_RESET;
    end else begin
      load_data <= load_hold_d;
    end
  end

  // Holds the last store lanes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_wdata <= DATA_RESET;
    end else begin
      bus_wdata <= wdata_hold_d;
    end
  end

  // Lanes drop to idle after each store
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lane_en <= LANES_NONE;
    end else begin
      lane_en <= store_v_d ? lane_d : LANES_NONE;
    end
  end

endmodule : lane_steer
`default_nettype wire

// ### hw/lane_steer_pkg.sv
// Constants for the byte-lane steering block
package lane_steer_pkg;
  localparam int          DATA_W        = 32;
  localparam int          LANES         = 4;
  localparam logic [1:0]  OFS_ZERO      = 2'h0;
  localparam logic        ORDER_LITTLE  = 1'h0;
  localparam logic        ORDER_BIG     = 1'h1;
  localparam logic        ORDER_RESET   = ORDER_LITTLE;
  localparam logic [3:0]  LANES_ALL     = 4'hF;
  localparam logic [3:0]  LANES_NONE    = 4'h0;
  localparam logic [31:0] DATA_RESET    = 32'h0000_0000;
  typedef enum logic {
    SIZE_WORD,
    SIZE_BYTE
  } size_type;
endpackage : lane_steer_pkg

// ### sim/lane_steer_sva.sv
// Checker for the lane steering block
`timescale 1ns/10ps
`default_nettype none
module lane_steer_sva(input wire logic ref_clk, rst, req, req_write, req_byte, order_wr,
  order_big, order_q, load_valid, store_valid, input wire logic [3:0] lane_en);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence st_s; req && req_write; endsequence
  store_pulse_a: assert property (st_s |=> store_valid) else $error("no store");
  load_pulse_a: assert property (req && !req_write |=> load_valid) else $error("no load");
  word_lanes_a: assert property (st_s ##0 !req_byte |=> lane_en == 4'hF) else $error("wl");
  byte_lane_a: assert property (st_s ##0 req_byte |=> $onehot(lane_en)) else $error("bl");
  lane_idle_a: assert property (!(req && req_write) |=> lane_en == 4'h0) else $error("il");
  order_load_a: assert property (order_wr |=> order_q == $past(order_big)) else $error("ol");
  order_hold_a: assert property (!order_wr |=> $stable(order_q)) else $error("oh");
  reset_order_a: assert property ($fell(rst) |-> order_q == 1'h0) else $error("ro");
endmodule : lane_steer_sva
`default_nettype wire

// ### sim/mem_model.sv
// Memory model driving the read lanes
`timescale 1ns/10ps
`default_nettype none
module mem_model #(parameter logic [31:0] WORD = 32'h11223344)(input wire logic oe,
  output logic [31:0] bus_rdata);
  // Released bus shows the inverse, never the stale word
  assign bus_rdata = oe ? WORD : ~WORD;
endmodule : mem_model
`default_nettype wire

// ### sim/tb_lane_steer.sv
// Self-checking bench for the lane steering block
`timescale 1ns/10ps
`default_nettype none
module tb_lane_steer;
  localparam logic [31:0] W = 32'h1122_3344;

  logic        ref_clk      = 1'h0;
  logic        rst          = 1'h1;
  logic        order_wr     = 1'h0;
  logic        order_big    = 1'h0;
  logic        req          = 1'h0;
  logic        req_write    = 1'h0;
  logic        req_byte     = 1'h0;
  logic        req_internal = 1'h0;
  logic [1:0]  req_ofs      = 2'h0;
  logic [31:0] store_data   = W;
  logic [31:0] bus_rdata;
  logic        order_q;
  logic        load_valid;
  logic [31:0] load_data;
  logic        store_valid;
  logic [31:0] bus_wdata;
  logic [3:0]  lane_en;
  int          mismatches   = 0;
  int          n_compared   = 0;

  lane_steer uut (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .order_wr     (order_wr),
    .order_big    (order_big),
    .req          (req),
    .req_write    (req_write),
    .req_byte     (req_byte),
    .req_internal (req_internal),
    .req_ofs      (req_ofs),
    .store_data   (store_data),
    .bus_rdata    (bus_rdata),
    .order_q      (order_q),
    .load_valid   (load_valid),
    .load_data    (load_data),
    .store_valid  (store_valid),
    .bus_wdata    (bus_wdata),
    .lane_en      (lane_en)
  );

  mem_model #(.WORD(W)) mem (
    .oe        (req),
    .bus_rdata (bus_rdata)
  );

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One transfer; request stands for exactly one sampling edge
  task automatic xfer(input logic w, input logic b, input logic i, input logic [1:0] ofs);
    @(posedge ref_clk);
    req          <= 1'h1;
    req_write    <= w;
    req_byte     <= b;
    req_internal <= i;
    req_ofs      <= ofs;
    @(posedge ref_clk);
    req <= 1'h0;
    #1;
    chk({31'h0, w ? store_valid : load_valid}, 32'h1);
    chk({31'h0, w ? load_valid : store_valid}, 32'h0);
  endtask : xfer

  task automatic set_order(input logic big);
    @(posedge ref_clk);
    order_wr  <= 1'h1;
    order_big <= big;
    @(posedge ref_clk);
    order_wr  <= 1'h0;
    #1;
    chk({31'h0, order_q}, {31'h0, big});
    $display("order set done");
  endtask : set_order

  task automatic test_word_read(input logic big);
    logic [1:0] o;
    for (int j = 0; j < 4; j++) begin
      o = 2'(j);
      xfer(1'h0, 1'h0, 1'h0, o);
      chk(load_data, 32'({W, W} >> (8 * o)));
    end
    $display("word read done, big %0d", big);
  endtask : test_word_read

  task automatic test_byte_read(input logic big);
    logic [1:0] o;
    logic [1:0] lane;
    for (int j = 0; j < 4; j++) begin
      o    = 2'(j);
      lane = big ? 2'h3 - o : o;
      xfer(1'h0, 1'h1, 1'h0, o);
      chk(load_data, {24'h0, W[8 * lane +: 8]});
    end
    $display("byte read done, big %0d", big);
  endtask : test_byte_read

  task automatic test_byte_write(input logic big);
    logic [1:0] o;
    logic [1:0] lane;
    for (int j = 0; j < 4; j++) begin
      o    = 2'(j);
      lane = big ? 2'h3 - o : o;
      xfer(1'h1, 1'h1, 1'h0, o);
      chk(bus_wdata, {4{W[7:0]}});
      chk({28'h0, lane_en}, 32'h1 << lane);
    end
    $display("byte write done, big %0d", big);
  endtask : test_byte_write

  task automatic test_word_write(input logic big);
    logic [1:0] o;
    for (int j = 0; j < 4; j++) begin
      o = 2'(j);
      xfer(1'h1, 1'h0, 1'h0, o);
      chk(bus_wdata, W);
      chk({28'h0, lane_en}, 32'hF);
    end
    $display("word write done, big %0d", big);
  endtask : test_word_write

  // Internal registers keep little-endian lanes in both orders
  task automatic test_internal(input logic big);
    logic [1:0] o;
    for (int j = 0; j < 4; j++) begin
      o = 2'(j);
      xfer(1'h0, 1'h1, 1'h1, o);
      chk(load_data, {24'h0, W[8 * o +: 8]});
      xfer(1'h1, 1'h1, 1'h1, o);
      chk({28'h0, lane_en}, 32'h1 << o);
    end
    $display("internal done, big %0d", big);
  endtask : test_internal

  // Request on the order-update edge still uses the old order
  task automatic test_order_edge;
    @(posedge ref_clk);
    order_wr     <= 1'h1;
    order_big    <= 1'h1;
    req          <= 1'h1;
    req_write    <= 1'h0;
    req_byte     <= 1'h1;
    req_internal <= 1'h0;
    req_ofs      <= 2'h0;
    @(posedge ref_clk);
    order_wr <= 1'h0;
    req      <= 1'h0;
    #1;
    chk(load_data, {24'h0, W[7:0]});
    chk({31'h0, order_q}, 32'h1);
    $display("order edge done");
  endtask : test_order_edge

  // Mid-run reset from big-endian mode
  task automatic test_reset;
    @(posedge ref_clk);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    #1;
    chk({31'h0, order_q}, 32'h0);
    chk(load_data, 32'h0);
    chk(bus_wdata, 32'h0);
    chk({28'h0, lane_en}, 32'h0);
    chk({30'h0, load_valid, store_valid}, 32'h0);
    $display("reset done");
  endtask : test_reset

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    #1;
    chk({31'h0, order_q}, 32'h0);
    test_word_read(1'h0);
    test_byte_read(1'h0);
    test_byte_write(1'h0);
    test_word_write(1'h0);
    test_internal(1'h0);
    test_order_edge();
    test_word_read(1'h1);
    test_byte_read(1'h1);
    test_byte_write(1'h1);
    test_word_write(1'h1);
    test_internal(1'h1);
    test_reset();
    test_byte_read(1'h0);
    set_order(1'h1);
    test_byte_write(1'h1);
    set_order(1'h0);
    test_byte_read(1'h0);
    finish_test();
  end
endmodule : tb_lane_steer
bind lane_steer lane_steer_sva chk_i (
  .ref_clk     (ref_clk),
  .rst         (rst),
  .req         (req),
  .req_write   (req_write),
  .req_byte    (req_byte),
  .order_wr    (order_wr),
  .order_big   (order_big),
  .order_q     (order_q),
  .load_valid  (load_valid),
  .store_valid (store_valid),
  .lane_en     (lane_en)
);
`default_nettype wire
